// ### bench/i2cmcs_bus_model.sv
// shift engine and bus stand-in: answers each operation after a short or long delay
`timescale 1ns/100ps
`default_nettype none
module i2cmcs_bus_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // operation from the block
  input wire i2cmcs_pkg::i2cmcs_op_e eng_op,
  // behaviour chosen by the bench
  input wire logic slow,
  input wire logic nack,
  input wire logic lose,
  input wire logic [7:0] rx_byte,
  // events back to the block
  output logic ev_addr_done,
  output logic ev_byte_wr_done,
  output logic ev_byte_rd_done,
  output logic ev_ack_bit,
  output logic ev_arb_lost,
  output logic ev_bus_err,
  output logic [7:0] ev_rx_byte,
  output logic eng_busy,
  output logic scl_pin,
  output logic sda_pin
);
  import i2cmcs_pkg::*;
  i2cmcs_op_e op_r;
  int cnt_r;
  assign ev_ack_bit = nack;
  assign ev_bus_err = 1'b0;
  assign ev_rx_byte = rx_byte;
  assign eng_busy = (cnt_r != 0);
  // pulled up when idle, so a stale level never looks like activity
  assign sda_pin = eng_busy ? cnt_r[0] : 1'b1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= I2CMCS_OP_IDLE;
      cnt_r <= 0;
      scl_pin <= 1'b1;
      {ev_addr_done, ev_byte_wr_done, ev_byte_rd_done, ev_arb_lost} <= 4'h0;
    end else begin
      {ev_addr_done, ev_byte_wr_done, ev_byte_rd_done, ev_arb_lost} <= 4'h0;
      if (cnt_r == 0 && eng_op != I2CMCS_OP_IDLE) begin
        op_r <= eng_op;
        cnt_r <= slow ? 40 : 3;
      end else if (cnt_r == 1) begin
        cnt_r <= 0;
        scl_pin <= 1'b1;
        ev_arb_lost <= lose;
        ev_addr_done <= (op_r == I2CMCS_OP_START);
        ev_byte_wr_done <= (op_r == I2CMCS_OP_SEND);
        ev_byte_rd_done <= (op_r == I2CMCS_OP_READ);
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1;
        // 80 ns link clock, only inside a frame
        if (cnt_r % 10 == 0) scl_pin <= ~scl_pin;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the master control block
`timescale 1ns/100ps
`default_nettype none
`include "i2cmcs_params.svh"
module testbench;
  import i2cmcs_pkg::*;
  localparam logic [11:0] A_SET = {`I2CMCS_IDX_SETUP, 2'b00};
  localparam logic [11:0] A_CMD = {`I2CMCS_IDX_CMD, 2'b00};
  localparam logic [11:0] A_ST = {`I2CMCS_IDX_STAT, 2'b00};
  localparam logic [11:0] A_TGT = {`I2CMCS_IDX_TARGET, 2'b00};
  localparam logic [11:0] A_DAT = {`I2CMCS_IDX_SHIFT, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_gie = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, read_irq, write_irq, scl_pin, sda_pin, eng_busy;
  logic ev_addr_done, ev_byte_wr_done, ev_byte_rd_done, ev_ack_bit, ev_arb_lost, ev_bus_err;
  logic [7:0] ev_rx_byte, eng_target_byte, eng_shift_byte, rxb = 0;
  logic [1:0] bs = 0;
  logic eng_ack_go, eng_ack_nack, master_enable, flush_strobe, bus_force_idle;
  logic slow = 0, nack = 0, lose = 0, last_nack;
  i2cmcs_op_e eng_op, last_op;
  int bad_count = 0, checked = 0, seed = 92, ack_n = 0, flush_n = 0, idle_n = 0;
  always #2 pclk = ~pclk;
  i2cmcs_core #(.TO1_CYC(20), .TO2_CYC(40), .TO3_CYC(80)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_gie(cpu_gie),
    .read_irq(read_irq), .write_irq(write_irq), .scl_pin(scl_pin), .sda_pin(sda_pin),
    .ev_addr_done(ev_addr_done), .ev_byte_wr_done(ev_byte_wr_done),
    .ev_byte_rd_done(ev_byte_rd_done), .ev_ack_bit(ev_ack_bit), .ev_arb_lost(ev_arb_lost),
    .ev_bus_err(ev_bus_err), .ev_rx_byte(ev_rx_byte), .eng_busy(eng_busy),
    .eng_bus_state(bs), .eng_op(eng_op), .eng_ack_go(eng_ack_go),
    .eng_ack_nack(eng_ack_nack), .eng_target_byte(eng_target_byte),
    .eng_shift_byte(eng_shift_byte), .master_enable(master_enable),
    .flush_strobe(flush_strobe), .bus_force_idle(bus_force_idle));
  i2cmcs_bus_model far (.pclk(pclk), .presetn(presetn), .eng_op(eng_op), .slow(slow),
    .nack(nack), .lose(lose), .rx_byte(rxb), .ev_addr_done(ev_addr_done),
    .ev_byte_wr_done(ev_byte_wr_done), .ev_byte_rd_done(ev_byte_rd_done),
    .ev_ack_bit(ev_ack_bit), .ev_arb_lost(ev_arb_lost), .ev_bus_err(ev_bus_err),
    .ev_rx_byte(ev_rx_byte), .eng_busy(eng_busy), .scl_pin(scl_pin), .sda_pin(sda_pin));

  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, A_ST, 8'h00);
      n++;
    end while (rd[b] !== 1'b1 && n < 80);
    if (n >= 80) begin
      bad_count++;
      give_verdict();
    end
  endtask
  // one-cycle pulses are sampled mid-cycle, where they have settled
  always @(negedge pclk) begin
    if (eng_op !== I2CMCS_OP_IDLE) last_op = eng_op;
    if (eng_ack_go === 1'b1) begin
      ack_n++;
      last_nack = eng_ack_nack;
    end
    if (flush_strobe === 1'b1) begin
      flush_n++;
      chk(master_enable, 0);
    end
    if (bus_force_idle === 1'b1) idle_n++;
  end

  initial begin
    int i, n, lim, a0;
    logic [7:0] t, d;
    logic [1:0] c;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // index 6 is skipped: setup, command, status, target, data
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 12'h00c + 12'(4 * i) + (i > 2 ? 12'h004 : 12'h000), 8'h00);
      chk({err, rd}, 0);
    end
    apb(1'b1, 12'h018, 8'hff);
    chk({err, rd}, 33'h100000000);
    bs <= 2'($random(seed));
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      apb(1'b1, A_SET, d);
      apb(1'b0, A_SET, 8'h00);
      chk(rd, d & `I2CMCS_SETUP_MASK);
    end
    apb(1'b1, A_CMD, 8'h04);
    apb(1'b0, A_CMD, 8'h00);
    chk(rd, 8'h04);
    apb(1'b0, A_ST, 8'h00);
    chk(rd[1:0], bs);
    apb(1'b1, A_SET, 8'h41);
    cpu_gie <= 1'b1;
    for (i = 0; i < 4; i++) begin
      nack <= i[0];
      slow <= i[1];
      t = 8'($random(seed)) & 8'hfe;
      // address goes out before data
      apb(1'b1, A_TGT, t);
      wait_st(6);
      chk(rd[7:3], {3'b011, nack, 1'b0});
      chk({write_irq, eng_target_byte, last_op}, {1'b1, t, I2CMCS_OP_START});
      d = 8'($random(seed));
      apb(1'b1, A_DAT, d);
      apb(1'b0, A_ST, 8'h00);
      if (slow) chk({rd[7:5], write_irq}, 0);
      wait_st(6);
      chk({rd[5:4], eng_shift_byte, last_op}, {1'b1, nack, d, I2CMCS_OP_SEND});
    end
    cpu_gie <= 1'b0;
    @(posedge pclk);
    chk(write_irq, 0);
    cpu_gie <= 1'b1;
    nack <= 1'b0;
    slow <= 1'b0;
    apb(1'b1, A_SET, 8'h83);
    // ack choice back to ack, left at nack by the readback test
    apb(1'b1, A_CMD, 8'h00);
    rxb <= 8'($random(seed));
    apb(1'b1, A_TGT, 8'ha5);
    wait_st(7);
    chk({read_irq, last_op}, {1'b1, I2CMCS_OP_READ});
    n = ack_n;
    apb(1'b0, A_DAT, 8'h00);
    chk(rd, rxb);
    wait_st(7);
    chk({ack_n - n, last_nack, last_op}, {32'd1, 1'b0, I2CMCS_OP_READ});
    apb(1'b1, A_ST, 8'h80);
    apb(1'b0, A_ST, 8'h00);
    chk({rd[7], read_irq}, 0);
    apb(1'b1, A_SET, 8'h91);
    apb(1'b1, A_TGT, 8'h33);
    wait_st(7);
    chk(last_op, I2CMCS_OP_START);
    nack <= 1'b1;
    apb(1'b1, A_TGT, 8'h35);
    wait_st(6);
    chk(rd[7:6], 2'b01);
    nack <= 1'b0;
    apb(1'b1, A_SET, 8'h01);
    for (i = 0; i < 6; i++) begin
      slow <= 1'b1;
      a0 = $random(seed) & 1;
      c = 2'(i % 3 + 1);
      apb(1'b1, A_TGT, 8'h50 | 8'(a0));
      wait_st(a0 ? 7 : 6);
      n = ack_n;
      apb(1'b1, A_CMD, {5'h0, 1'(i / 3), c});
      repeat (4) @(posedge pclk);
      chk(last_op, c == 1 ? I2CMCS_OP_START : c == 3 ? I2CMCS_OP_STOP :
        a0 ? I2CMCS_OP_READ : I2CMCS_OP_SEND);
      chk(ack_n - n, a0);
      if (a0) chk(last_nack, i / 3);
      apb(1'b0, A_ST, 8'h00);
      chk(rd[7:5], 0);
      apb(1'b0, A_CMD, 8'h00);
      chk(rd, {5'h0, 1'(i / 3), 2'b00});
      repeat (90) @(posedge pclk);
    end
    slow <= 1'b0;
    lose <= 1'b1;
    apb(1'b1, A_TGT, 8'h42);
    wait_st(6);
    chk({rd[5], rd[3]}, 2'b01);
    lose <= 1'b0;
    apb(1'b1, A_DAT, 8'h11);
    wait_st(6);
    chk(rd[3], 1);
    apb(1'b1, A_ST, 8'h08);
    apb(1'b0, A_ST, 8'h00);
    chk(rd[3], 0);
    lose <= 1'b1;
    apb(1'b1, A_TGT, 8'h42);
    wait_st(6);
    lose <= 1'b0;
    apb(1'b1, A_TGT, 8'h42);
    wait_st(6);
    chk(rd[3], 0);
    flush_n = 0;
    apb(1'b1, A_CMD, 8'h08);
    apb(1'b1, A_CMD, 8'h00);
    chk({flush_n, master_enable, eng_target_byte}, {32'd1, 1'b1, 8'h00});
    apb(1'b1, A_SET, 8'h00);
    chk(master_enable, 0);
    for (i = 0; i < 4; i++) begin
      idle_n = 0;
      apb(1'b1, A_SET, {4'h0, 2'(i), 2'b01});
      n = 0;
      while (idle_n == 0 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      lim = (i == 0) ? 200 : 20 << (i - 1);
      chk(n >= lim - 4 && n <= lim + 8, 1);
      apb(1'b1, A_SET, 8'h00);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// ### logic/i2cmcs_core.sv
// control and status registers of a two-wire bus master, apb slave
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "i2cmcs_params.svh"

module i2cmcs_core #(
  parameter int unsigned TO1_CYC = `I2CMCS_TO1_US * 1000 / `I2CMCS_CLK_NS,
  parameter int unsigned TO2_CYC = `I2CMCS_TO2_US * 1000 / `I2CMCS_CLK_NS,
  parameter int unsigned TO3_CYC = `I2CMCS_TO3_US * 1000 / `I2CMCS_CLK_NS
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`I2CMCS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic cpu_gie,
  output logic read_irq,
  output logic write_irq,
  // bus pins, asynchronous
  input wire logic scl_pin,
  input wire logic sda_pin,
  // events from the shift engine, same clock
  input wire logic ev_addr_done,
  input wire logic ev_byte_wr_done,
  input wire logic ev_byte_rd_done,
  input wire logic ev_ack_bit,
  input wire logic ev_arb_lost,
  input wire logic ev_bus_err,
  input wire logic [7:0] ev_rx_byte,
  input wire logic eng_busy,
  input wire logic [1:0] eng_bus_state,
  // commands to the shift engine
  output i2cmcs_pkg::i2cmcs_op_e eng_op,
  output logic eng_ack_go,
  output logic eng_ack_nack,
  output logic [7:0] eng_target_byte,
  output logic [7:0] eng_shift_byte,
  output logic master_enable,
  output logic flush_strobe,
  output logic bus_force_idle
);
  import i2cmcs_pkg::*;

  logic [7:0] setup_r;
  logic ack_choice_r;
  logic [7:0] target_r;
  logic [7:0] shift_r;
  logic rd_flag_r, wr_flag_r, hold_flag_r, last_slave_ack_r, arb_flag_r, berr_flag_r;
  logic op_fault_r;
  logic scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r;
  logic [`I2CMCS_TO_CNT_W-1:0] idle_cnt_r, to_lim;
  logic to_fire_r;

  logic acc, wr_acc, rd_acc, aligned;
  logic sel_setup, sel_cmd, sel_stat, sel_target, sel_shift;
  logic w_target, w_shift, r_shift, w_cmd, w_stat, valid_cmd, flush, hold_clr;
  logic dir_read, quick, rd_path, rd_set, wr_set, hold_set;
  logic activity, to_off, force_write;
  i2cmcs_cmd_e new_cmd;
  logic [7:0] wbyte, rd_byte, cmd_view, stat_view;

  // apb decode; zero wait states
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign aligned = (paddr[1:0] == 2'h0);
  assign sel_setup = aligned & (paddr[`I2CMCS_AW-1:2] == `I2CMCS_IDX_SETUP);
  assign sel_cmd = aligned & (paddr[`I2CMCS_AW-1:2] == `I2CMCS_IDX_CMD);
  assign sel_stat = aligned & (paddr[`I2CMCS_AW-1:2] == `I2CMCS_IDX_STAT);
  assign sel_target = aligned & (paddr[`I2CMCS_AW-1:2] == `I2CMCS_IDX_TARGET);
  assign sel_shift = aligned & (paddr[`I2CMCS_AW-1:2] == `I2CMCS_IDX_SHIFT);
  assign pready = 1'b1;
  assign pslverr = acc & ~(sel_setup | sel_cmd | sel_stat | sel_target | sel_shift);

  assign wbyte = pwdata[7:0];
  assign new_cmd = i2cmcs_cmd_e'(pwdata[`I2CMCS_CMD_OP_HI:`I2CMCS_CMD_OP_LO]);
  assign w_target = wr_acc & sel_target;
  // writes to the shift register are dropped while a byte is on the wire
  assign w_shift = wr_acc & sel_shift & ~eng_busy;
  assign r_shift = rd_acc & sel_shift;
  assign w_cmd = wr_acc & sel_cmd;
  assign w_stat = wr_acc & sel_stat;
  // op field only acts on write
  assign valid_cmd = w_cmd & (new_cmd != OP_NONE);
  assign flush = w_cmd & pwdata[`I2CMCS_CMD_FLUSH];
  assign hold_clr = w_target | w_shift | r_shift | valid_cmd | flush;

  assign dir_read = target_r[0];
  assign quick = setup_r[`I2CMCS_SETUP_QCE];
  assign rd_path = ev_addr_done & dir_read & ~ev_ack_bit & ~ev_arb_lost & ~ev_bus_err;
  // clean read only; quick read flags at address ack
  assign rd_set = (ev_byte_rd_done & ~op_fault_r & ~ev_arb_lost & ~ev_bus_err)
                | (quick & rd_path & ~op_fault_r);
  // address or byte write end, faults regardless
  assign wr_set = ev_byte_wr_done | (ev_addr_done & ~rd_path);
  // scl stays low after a completion unless ownership was lost or a bus error came earlier in the operation
  assign hold_set = (rd_set | wr_set) & ~ev_arb_lost & ~op_fault_r;

  assign read_irq = setup_r[`I2CMCS_SETUP_RIE] & rd_flag_r & cpu_gie;
  assign write_irq = setup_r[`I2CMCS_SETUP_WIE] & wr_flag_r & cpu_gie;
  // enable, dropped for the flush cycle
  assign master_enable = setup_r[`I2CMCS_SETUP_EN] & ~flush_strobe;
  assign eng_target_byte = target_r;
  assign eng_shift_byte = shift_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_r <= `I2CMCS_RST8;
    end else if (wr_acc & sel_setup) begin
      setup_r <= wbyte & `I2CMCS_SETUP_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_choice_r <= 1'b0;
    end else if (w_cmd) begin
      ack_choice_r <= pwdata[`I2CMCS_CMD_ACK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_r <= `I2CMCS_RST8;
    end else if (flush) begin
      target_r <= `I2CMCS_RST8;
    end else if (w_target) begin
      target_r <= wbyte;
    end
  end

  // data written before address goes out as is; flush recovers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= `I2CMCS_RST8;
    end else if (flush) begin
      shift_r <= `I2CMCS_RST8;
    end else if (w_shift) begin
      shift_r <= wbyte;
    end else if (ev_byte_rd_done) begin
      shift_r <= ev_rx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_strobe <= 1'b0;
    end else begin
      flush_strobe <= flush;
    end
  end

  // engine commands, one-cycle pulses; eng_ack_nack holds its value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_op <= I2CMCS_OP_IDLE;
      eng_ack_go <= 1'b0;
      eng_ack_nack <= 1'b0;
    end else begin
      eng_op <= I2CMCS_OP_IDLE;
      eng_ack_go <= 1'b0;
      if (flush) begin
        eng_op <= I2CMCS_OP_IDLE;
      end else if (w_target) begin
        eng_op <= I2CMCS_OP_START;
      end else if (valid_cmd) begin
        // the ack choice in this same write applies
        eng_ack_go <= dir_read;
        eng_ack_nack <= pwdata[`I2CMCS_CMD_ACK];
        unique case (new_cmd)
          OP_RESTART: eng_op <= I2CMCS_OP_START;
          OP_NEXT_BYTE: eng_op <= dir_read ? I2CMCS_OP_READ : I2CMCS_OP_SEND;
          OP_HALT: eng_op <= I2CMCS_OP_STOP;
          OP_NONE: eng_op <= I2CMCS_OP_IDLE;
        endcase
      end else if (w_shift) begin
        eng_op <= I2CMCS_OP_SEND;
      end else if (r_shift & setup_r[`I2CMCS_SETUP_SMART]) begin
        // smart mode acks on data read, nack ends the read
        eng_ack_go <= 1'b1;
        eng_ack_nack <= ack_choice_r;
        eng_op <= ack_choice_r ? I2CMCS_OP_IDLE : I2CMCS_OP_READ;
      end else if (rd_path & ~quick) begin
        eng_op <= I2CMCS_OP_READ;
      end
    end
  end

  // fault seen since the last operation was issued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_fault_r <= 1'b0;
    end else if (ev_arb_lost | ev_bus_err) begin
      op_fault_r <= 1'b1;
    end else if (eng_op != I2CMCS_OP_IDLE) begin
      op_fault_r <= 1'b0;
    end
  end

  // flag updates: a set in the clearing cycle wins
  // read flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_flag_r <= 1'b0;
    end else if (rd_set) begin
      rd_flag_r <= 1'b1;
    end else if (hold_clr | (w_stat & pwdata[`I2CMCS_ST_RD])) begin
      rd_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_flag_r <= 1'b0;
    end else if (wr_set) begin
      wr_flag_r <= 1'b1;
    end else if (hold_clr | (w_stat & pwdata[`I2CMCS_ST_WR])) begin
      wr_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_flag_r <= 1'b0;
    end else if (hold_set) begin
      hold_flag_r <= 1'b1;
    end else if (hold_clr | (w_stat & pwdata[`I2CMCS_ST_HOLD])) begin
      hold_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_slave_ack_r <= 1'b0;
    end else if (ev_addr_done | ev_byte_wr_done) begin
      last_slave_ack_r <= ev_ack_bit;
    end
  end

  // loss flag set; address write, flush or one clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_flag_r <= 1'b0;
    end else if (ev_arb_lost) begin
      arb_flag_r <= 1'b1;
    end else if (w_target | flush | (w_stat & pwdata[`I2CMCS_ST_ARB])) begin
      arb_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      berr_flag_r <= 1'b0;
    end else if (ev_bus_err) begin
      berr_flag_r <= 1'b1;
    end else if (w_target | flush | (w_stat & pwdata[`I2CMCS_ST_BERR])) begin
      berr_flag_r <= 1'b0;
    end
  end

  // pin synchronisers, third stage only for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_pin, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_pin, sda_s1_r, sda_s2_r};
    end
  end

  // interval select; figures hold for a 4 ns clock only
  always_comb begin
    unique case (setup_r[`I2CMCS_SETUP_TO_HI:`I2CMCS_SETUP_TO_LO])
      2'h1: to_lim = `I2CMCS_TO_CNT_W'(TO1_CYC);
      2'h2: to_lim = `I2CMCS_TO_CNT_W'(TO2_CYC);
      2'h3: to_lim = `I2CMCS_TO_CNT_W'(TO3_CYC);
      default: to_lim = '0;
    endcase
  end

  assign activity = (scl_s2_r ^ scl_s3_r) | (sda_s2_r ^ sda_s3_r);
  assign to_off = (to_lim == '0) | ~setup_r[`I2CMCS_SETUP_EN];

  // counter saturates so the timeout fires once per quiet spell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= '0;
      to_fire_r <= 1'b0;
    end else begin
      to_fire_r <= ~activity & ~to_off & (idle_cnt_r == to_lim - 1'b1);
      if (activity | to_off) begin
        idle_cnt_r <= '0;
      end else if (idle_cnt_r != to_lim) begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
    end
  end

  assign force_write = w_stat &
    (pwdata[`I2CMCS_ST_BS_HI:`I2CMCS_ST_BS_LO] == `I2CMCS_BS_IDLE);
  assign bus_force_idle = to_fire_r | force_write;

  // read path; reserved and strobe bits read zero
  always_comb begin
    cmd_view = `I2CMCS_RST8;
    cmd_view[`I2CMCS_CMD_ACK] = ack_choice_r;
    stat_view = `I2CMCS_RST8;
    stat_view[`I2CMCS_ST_RD] = rd_flag_r;
    stat_view[`I2CMCS_ST_WR] = wr_flag_r;
    stat_view[`I2CMCS_ST_HOLD] = hold_flag_r;
    stat_view[`I2CMCS_ST_LAST_SLAVE_ACK] = last_slave_ack_r;
    stat_view[`I2CMCS_ST_ARB] = arb_flag_r;
    stat_view[`I2CMCS_ST_BERR] = berr_flag_r;
    stat_view[`I2CMCS_ST_BS_HI:`I2CMCS_ST_BS_LO] = eng_bus_state;
    rd_byte = `I2CMCS_RST8;
    if (sel_setup) rd_byte = setup_r;
    if (sel_cmd) rd_byte = cmd_view;
    if (sel_stat) rd_byte = stat_view;
    if (sel_target) rd_byte = target_r;
    if (sel_shift) rd_byte = shift_r;
    prdata = {24'h000000, rd_byte};
  end

  a_read_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_byte_rd_done && !op_fault_r && !ev_arb_lost && !ev_bus_err &&
      setup_r[`I2CMCS_SETUP_RIE] && cpu_gie) ##1 cpu_gie |-> read_irq)
    else $error("read irq missing after byte read");

  a_write_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ev_byte_wr_done && setup_r[`I2CMCS_SETUP_WIE] && cpu_gie ##1 cpu_gie |-> write_irq)
    else $error("write irq missing after byte write");

  a_quick_read_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (quick && rd_path && !op_fault_r) |=> rd_flag_r && eng_op == I2CMCS_OP_IDLE)
    else $error("quick command read flag wrong");

  a_flush_strobe_once: assert property (@(posedge pclk) disable iff (!presetn)
    flush |=> flush_strobe && !master_enable && target_r == `I2CMCS_RST8
      ##1 (!flush_strobe || $past(flush)))
    else $error("flush strobe wrong");

  a_cmd_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel_cmd) |-> prdata[`I2CMCS_CMD_OP_HI:`I2CMCS_CMD_OP_LO] == 2'h0)
    else $error("command bits read nonzero");

  a_stop_cmd_op: assert property (@(posedge pclk) disable iff (!presetn)
    (valid_cmd && !flush && !w_target && new_cmd == OP_HALT) |=> eng_op == I2CMCS_OP_STOP)
    else $error("stop command not issued");

  a_ack_same_write: assert property (@(posedge pclk) disable iff (!presetn)
    (valid_cmd && !flush && !w_target && dir_read)
      |=> eng_ack_go && eng_ack_nack == $past(pwdata[`I2CMCS_CMD_ACK]))
    else $error("ack choice of the write not used");

  a_hold_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    (w_shift && !hold_set && !wr_set) |=> !hold_flag_r && !wr_flag_r)
    else $error("hold flag not cleared by data write");

  a_arb_set: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_arb_lost && !hold_flag_r) |=> arb_flag_r && !hold_flag_r)
    else $error("arbitration loss not flagged");

  a_arb_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (w_target && !ev_arb_lost) |=> !arb_flag_r && eng_op == I2CMCS_OP_START)
    else $error("address write did not clear loss");

  a_timeout_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(to_fire_r) |-> $past(idle_cnt_r) == to_lim - 1'b1 && !to_off)
    else $error("timeout fired without quiet interval");
endmodule
`default_nettype wire

// ### logic/i2cmcs_params.svh
// register map, field positions and timing figures of the master control block
`ifndef I2CMCS_PARAMS_SVH
`define I2CMCS_PARAMS_SVH

// apb geometry; register index n sits at byte address 4*n
`define I2CMCS_AW 12
`define I2CMCS_IDX_W 10
`define I2CMCS_IDX_SETUP 10'h003
`define I2CMCS_IDX_CMD 10'h004
`define I2CMCS_IDX_STAT 10'h005
`define I2CMCS_IDX_TARGET 10'h007
`define I2CMCS_IDX_SHIFT 10'h008

// master_setup_control fields
`define I2CMCS_SETUP_RIE 7
`define I2CMCS_SETUP_WIE 6
`define I2CMCS_SETUP_QCE 4
`define I2CMCS_SETUP_TO_HI 3
`define I2CMCS_SETUP_TO_LO 2
`define I2CMCS_SETUP_SMART 1
`define I2CMCS_SETUP_EN 0
`define I2CMCS_SETUP_MASK 8'hdf

// master_command_control fields
`define I2CMCS_CMD_FLUSH 3
`define I2CMCS_CMD_ACK 2
`define I2CMCS_CMD_OP_HI 1
`define I2CMCS_CMD_OP_LO 0

// master_status_flags fields
`define I2CMCS_ST_RD 7
`define I2CMCS_ST_WR 6
`define I2CMCS_ST_HOLD 5
`define I2CMCS_ST_LAST_SLAVE_ACK 4
`define I2CMCS_ST_ARB 3
`define I2CMCS_ST_BERR 2
`define I2CMCS_ST_BS_HI 1
`define I2CMCS_ST_BS_LO 0
`define I2CMCS_BS_IDLE 2'h1

`define I2CMCS_RST8 8'h00

// inactive-bus timeouts in microseconds, clock period in nanoseconds
`define I2CMCS_TO1_US 50
`define I2CMCS_TO2_US 100
`define I2CMCS_TO3_US 200
`define I2CMCS_CLK_NS 4
`define I2CMCS_TO_CNT_W 16

`endif

// ### logic/i2cmcs_pkg.sv
// types shared by the master control block
package i2cmcs_pkg;
  typedef enum logic [2:0] {
    I2CMCS_OP_IDLE = 3'h0,
    I2CMCS_OP_START = 3'h1,
    I2CMCS_OP_READ = 3'h2,
    I2CMCS_OP_SEND = 3'h3,
    I2CMCS_OP_STOP = 3'h4
  } i2cmcs_op_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_RESTART = 2'h1,
    OP_NEXT_BYTE = 2'h2,
    OP_HALT = 2'h3
  } i2cmcs_cmd_e;
endpackage
